// ### rtl/spi_rate_pkg.sv
/*
 package for the serial bit-rate and status flag block: register offsets,
 field positions, reset values and the small structs that carry controls.
 assumes a single 100 MHz bus clock and a byte-wide register port.
*/
package spi_rate_pkg;

	// register offsets on the plain register port
	localparam logic [2:0] CTRL_ONE_OFFSET   = 3'h0;
	localparam logic [2:0] CTRL_TWO_OFFSET   = 3'h1;
	localparam logic [2:0] BIT_RATE_OFFSET   = 3'h2;
	localparam logic [2:0] FLAG_STATUS_OFFSET = 3'h3;
	localparam logic [2:0] DATA_PORT_OFFSET  = 3'h5;

	// control register one fields
	localparam int RX_IRQ_EN_BIT    = 7;
	localparam int UNIT_EN_BIT      = 6;
	localparam int TX_IRQ_EN_BIT    = 5;
	localparam int MASTER_SEL_BIT   = 4;
	localparam int SEL_OUT_EN_BIT   = 1;
	// control register two fields
	localparam int FAULT_DET_EN_BIT = 4;

	// bit rate fields
	localparam int PRESCALE_LSB = 4;
	localparam int RATE_LSB     = 0;

	// status fields
	localparam int RX_FULL_BIT  = 7;
	localparam int TX_EMPTY_BIT = 5;
	localparam int FAULT_BIT    = 4;
	localparam logic [7:0] STATUS_IMPL_MASK = 8'hb0;

	// reset values and write masks
	localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
	localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
	localparam logic [7:0] BIT_RATE_RESET = 8'h00;
	localparam logic [7:0] BIT_RATE_MASK  = 8'h77;
	localparam logic [7:0] CTRL_TWO_MASK  = 8'h1b;

	// half-bit edges per transfer
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_s;

	typedef struct packed {
		logic rx_irq_en;
		logic unit_en;
		logic tx_irq_en;
		logic master_sel;
		logic fault_det_en;
		logic sel_out_en;
	} ctrl_s;

endpackage

// ### rtl/spi_rate_flags.sv
/*
 bit-rate generator and status flags of a serial peripheral unit, with
 transmit buffer, shifter handoff and receive buffer.
 assumes synchronous pins and a register master that never waits.
*/
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - prescaler divides bus clock by prescale_code plus one.
// - divider further divides by two to the power rate_divide_code plus one.
// - bit_rate_select is readable and writable at any time.
// - unimplemented status bits 6,3,2,1,0 read zero.
// - writes to serial_flag_status are ignored.
// - receive_full_flag sets when a finished byte reaches the receive buffer.
// - receive_full_flag clears by status read with flag set then data read.
// - transmit_empty_flag clears by status read with flag set then data write.
// - data write without prior status read seeing empty is discarded.
// - transmit interrupt when transmit empty and transmit enable set.
// - transmit_empty_flag sets whenever buffer byte moves to shifter.
// - idle master unit moves written byte to shifter within two bus cycles.
// - finished shifter takes any queued buffer byte and sets empty flag.
// - with nothing queued, empty flag stays set and nothing moves.
// - mode_fault_flag sets when master and select input driven low.
// - fault only when master, fault detect on, select output off.
// - mode_fault_flag clears by status read with flag set then control one write.
// - receive interrupt when receive full or fault and its enable set.
// - unit disable aborts transfer, flushes buffers, clears full, sets empty.
// - byte finishing while receive buffer full is dropped silently.
module spi_rate_flags
(
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_n_i,
	// register port
	input  wire spi_rate_pkg::reg_req_s   req_i,
	output logic      [7:0]               rdata_o,
	// serial pins
	input  wire logic                     select_n_i,
	input  wire logic                     serial_in_i,
	output logic                          serial_out_o,
	output logic                          serial_clk_o,
	output logic                          select_n_o,
	output logic                          select_oe_o,
	// processor requests
	output logic                          irq_o
);
	import spi_rate_pkg::*;

	typedef enum logic [1:0] {SH_IDLE, SH_LOAD, SH_RUN} shift_e;

	logic [7:0] ctrl_one_reg;
	logic [7:0] ctrl_two_reg;
	logic [7:0] bit_rate_reg;
	logic [7:0] rdata_reg;
	logic [7:0] tx_buf_reg;
	logic       tx_full_reg;
	logic [7:0] shift_reg;
	logic [7:0] rx_buf_reg;
	logic       rx_full_reg;
	logic       tx_armed_reg;
	logic       rx_armed_reg;
	logic       fault_armed_reg;
	logic       fault_reg;
	logic [2:0] pre_cnt_reg;
	logic [7:0] div_cnt_reg;
	logic [4:0] edge_cnt_reg;
	logic       sclk_reg;
	shift_e     state_reg;
	ctrl_s      ctrl;
	logic       wr_data;
	logic       rd_data;
	logic       rd_status;
	logic       wr_ctrl_one;
	logic       tx_accept;
	logic       bit_tick;
	logic       byte_done;
	logic       fault_mode;
	logic [7:0] status;
	logic [7:0] div_top;

	function automatic logic hit(input reg_req_s r, input logic [2:0] off);
		hit = (r.addr == off);
	endfunction

	assign ctrl.rx_irq_en    = ctrl_one_reg[RX_IRQ_EN_BIT];
	assign ctrl.unit_en      = ctrl_one_reg[UNIT_EN_BIT];
	assign ctrl.tx_irq_en    = ctrl_one_reg[TX_IRQ_EN_BIT];
	assign ctrl.master_sel   = ctrl_one_reg[MASTER_SEL_BIT];
	assign ctrl.sel_out_en   = ctrl_one_reg[SEL_OUT_EN_BIT];
	assign ctrl.fault_det_en = ctrl_two_reg[FAULT_DET_EN_BIT];

	assign wr_data     = req_i.wr && hit(req_i, DATA_PORT_OFFSET);
	assign rd_data     = req_i.rd && hit(req_i, DATA_PORT_OFFSET);
	assign rd_status   = req_i.rd && hit(req_i, FLAG_STATUS_OFFSET);
	assign wr_ctrl_one = req_i.wr && hit(req_i, CTRL_ONE_OFFSET);
	// write lands only if armed by a status read that saw room
	assign tx_accept   = wr_data && tx_armed_reg && ctrl.unit_en;
	assign fault_mode  = ctrl.master_sel && ctrl.fault_det_en && !ctrl.sel_out_en;

	// flag empty means buffer has room
	always_comb
	begin
		status = 8'h00;
		status[RX_FULL_BIT]  = rx_full_reg;
		status[TX_EMPTY_BIT] = !tx_full_reg;
		status[FAULT_BIT]    = fault_reg;
		status = status & STATUS_IMPL_MASK;
	end

	// control registers
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			ctrl_one_reg <= CTRL_ONE_RESET;
			ctrl_two_reg <= CTRL_TWO_RESET;
			bit_rate_reg <= BIT_RATE_RESET;
		end
		else if (req_i.wr)
		begin
			if (hit(req_i, CTRL_ONE_OFFSET))
				ctrl_one_reg <= req_i.wdata;
			if (hit(req_i, CTRL_TWO_OFFSET))
				ctrl_two_reg <= req_i.wdata & CTRL_TWO_MASK;
			if (hit(req_i, BIT_RATE_OFFSET))
				bit_rate_reg <= req_i.wdata & BIT_RATE_MASK;
			// status writes fall through with no effect
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			rdata_reg <= 8'h00;
		else if (req_i.rd)
		begin
			unique case (req_i.addr)
				CTRL_ONE_OFFSET:    rdata_reg <= ctrl_one_reg;
				CTRL_TWO_OFFSET:    rdata_reg <= ctrl_two_reg;
				BIT_RATE_OFFSET:    rdata_reg <= bit_rate_reg;
				FLAG_STATUS_OFFSET: rdata_reg <= status;
				DATA_PORT_OFFSET:   rdata_reg <= rx_buf_reg;
				default:            rdata_reg <= 8'h00;
			endcase
		end
		else
			rdata_reg <= 8'h00;
	end
	assign rdata_o = rdata_reg;

	// arming flags: status read seen with flag set; any later status read re-evaluates
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			tx_armed_reg    <= 1'b0;
			rx_armed_reg    <= 1'b0;
			fault_armed_reg <= 1'b0;
		end
		else if (rd_status)
		begin
			tx_armed_reg    <= !tx_full_reg;
			rx_armed_reg    <= rx_full_reg;
			fault_armed_reg <= fault_reg;
		end
		else
		begin
			if (wr_data)
				tx_armed_reg <= 1'b0;
			if (rd_data)
				rx_armed_reg <= 1'b0;
			if (wr_ctrl_one)
				fault_armed_reg <= 1'b0;
		end
	end

	// prescaler then power-of-two divider; one tick per half bit
	assign div_top = 8'((16'h0001 << bit_rate_reg[RATE_LSB +: 3]) - 16'h0001);
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i || state_reg != SH_RUN)
		begin
			pre_cnt_reg <= 3'h0;
			div_cnt_reg <= 8'h00;
		end
		else if (pre_cnt_reg == bit_rate_reg[PRESCALE_LSB +: 3])
		begin
			pre_cnt_reg <= 3'h0;
			div_cnt_reg <= (div_cnt_reg == div_top) ? 8'h00 : div_cnt_reg + 8'h01;
		end
		else
			pre_cnt_reg <= pre_cnt_reg + 3'h1;
	end
	// divider spans rate divisor; one half-bit tick per span
	assign bit_tick = (state_reg == SH_RUN) && ctrl.master_sel
		&& (pre_cnt_reg == bit_rate_reg[PRESCALE_LSB +: 3])
		&& (div_cnt_reg[6:0] == div_top[7:1]);
	assign byte_done = bit_tick && (edge_cnt_reg == EDGES_PER_BYTE - 5'h01);

	// transmit buffer
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i || !ctrl.unit_en)
		begin
			tx_full_reg <= 1'b0;
			tx_buf_reg  <= 8'h00;
		end
		else if (tx_accept)
		begin
			tx_full_reg <= 1'b1;
			tx_buf_reg  <= req_i.wdata;
		end
		else if (tx_full_reg && (state_reg == SH_IDLE || byte_done))
			tx_full_reg <= 1'b0;
	end

	// shifter; slave-side shifting lives outside this block
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i || !ctrl.unit_en)
		begin
			state_reg    <= SH_IDLE;
			shift_reg    <= 8'h00;
			edge_cnt_reg <= 5'h00;
			sclk_reg     <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				SH_IDLE:
					if (tx_full_reg && ctrl.master_sel)
						state_reg <= SH_LOAD;
				SH_LOAD:
				begin
					shift_reg    <= tx_buf_reg;
					edge_cnt_reg <= 5'h00;
					state_reg    <= SH_RUN;
				end
				SH_RUN:
					if (bit_tick)
					begin
						sclk_reg     <= !sclk_reg;
						edge_cnt_reg <= edge_cnt_reg + 5'h01;
						if (sclk_reg)
							shift_reg <= {shift_reg[6:0], serial_in_i};
						if (byte_done)
							state_reg <= tx_full_reg ? SH_LOAD : SH_IDLE;
					end
			endcase
		end
	end
	assign serial_out_o = shift_reg[7];
	assign serial_clk_o = sclk_reg;
	assign select_n_o   = !(state_reg == SH_RUN);
	assign select_oe_o  = ctrl.unit_en && ctrl.master_sel && ctrl.fault_det_en && ctrl.sel_out_en;

	// receive buffer; a finished byte while full is dropped
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i || !ctrl.unit_en)
		begin
			rx_full_reg <= 1'b0;
			rx_buf_reg  <= 8'h00;
		end
		else if (byte_done && !rx_full_reg)
		begin
			rx_full_reg <= 1'b1;
			rx_buf_reg  <= {shift_reg[6:0], serial_in_i};
		end
		else if (rd_data && rx_armed_reg)
			rx_full_reg <= 1'b0;
	end

	// mode fault: set wins over clear
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			fault_reg <= 1'b0;
		else if (ctrl.unit_en && fault_mode && !select_n_i)
			fault_reg <= 1'b1;
		else if (wr_ctrl_one && fault_armed_reg)
			fault_reg <= 1'b0;
	end

	// one processor request line for both sources
	assign irq_o = (ctrl.tx_irq_en && !tx_full_reg)
		|| (ctrl.rx_irq_en && (rx_full_reg || fault_reg));

endmodule // spi_rate_flags

`default_nettype wire

// ### bench/spi_rate_chk.sv
/*
 port checker of spi_rate_flags: shadows control writes, watches pins.
 assumes the bind below and one bus clock.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_rate_chk
	import spi_rate_pkg::*;
(
	// clock and reset
	input wire logic                   clk_i,
	input wire logic                   reset_n_i,
	// register port and pins
	input wire spi_rate_pkg::reg_req_s req_i,
	input wire logic [7:0]             rdata_o,
	input wire logic                   serial_clk_o,
	input wire logic                   select_n_o,
	input wire logic                   select_oe_o,
	input wire logic                   irq_o
);
	import spi_rate_pkg::*;
	logic [7:0]  c1_reg;
	logic [7:0]  c2_reg;
	logic [7:0]  br_reg;
	logic [10:0] hi_cnt;
	logic [4:0]  fall_cnt;
	logic        st_rd;
	int          half;
	assign st_rd = req_i.rd && req_i.addr == FLAG_STATUS_OFFSET;
	assign half = (int'(br_reg[6:4]) + 1) << br_reg[2:0];
	// shadows of software writes
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			c1_reg <= CTRL_ONE_RESET;
			c2_reg <= CTRL_TWO_RESET;
			br_reg <= BIT_RATE_RESET;
		end
		else if (req_i.wr)
		begin
			if (req_i.addr == CTRL_ONE_OFFSET) c1_reg <= req_i.wdata;
			if (req_i.addr == CTRL_TWO_OFFSET) c2_reg <= req_i.wdata;
			if (req_i.addr == BIT_RATE_OFFSET) br_reg <= req_i.wdata & BIT_RATE_MASK;
		end
	end
	// pin counters; a fall on the closing edge is added in the property
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			hi_cnt <= 11'h000;
			fall_cnt <= 5'h00;
		end
		else
		begin
			hi_cnt <= serial_clk_o ? hi_cnt + 11'h001 : 11'h000;
			fall_cnt <= $fell(select_n_o) ? 5'h00 : fall_cnt + 5'($fell(serial_clk_o));
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	property p_status_zero;
		st_rd |=> (rdata_o & ~STATUS_IMPL_MASK) == 8'h00;
	endproperty
	a_status_zero: assert property (p_status_zero) else $error("status spare bits");
	property p_half_bit;
		$fell(serial_clk_o) && c1_reg[UNIT_EN_BIT] |-> int'(hi_cnt) == half;
	endproperty
	a_half_bit: assert property (p_half_bit) else $error("half bit length");
	property p_master_only;
		$rose(serial_clk_o) |-> c1_reg[MASTER_SEL_BIT] && c1_reg[UNIT_EN_BIT];
	endproperty
	a_master_only: assert property (p_master_only) else $error("clock not master");
	property p_sel_oe;
		select_oe_o == (c1_reg[UNIT_EN_BIT] && c1_reg[MASTER_SEL_BIT]
			&& c2_reg[FAULT_DET_EN_BIT] && c1_reg[SEL_OUT_EN_BIT]);
	endproperty
	a_sel_oe: assert property (p_sel_oe) else $error("select enable");
	property p_tx_irq;
		st_rd && c1_reg[TX_IRQ_EN_BIT] |=> !rdata_o[TX_EMPTY_BIT] || $past(irq_o);
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");
	property p_rx_irq;
		st_rd && c1_reg[RX_IRQ_EN_BIT] |=> !(rdata_o[RX_FULL_BIT] || rdata_o[FAULT_BIT])
			|| $past(irq_o);
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");
	property p_irq_quiet;
		st_rd && !c1_reg[TX_IRQ_EN_BIT] && !c1_reg[RX_IRQ_EN_BIT] |=> !$past(irq_o);
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq unmasked");
	property p_byte_len;
		$rose(select_n_o) && c1_reg[UNIT_EN_BIT]
			|-> fall_cnt + 5'($fell(serial_clk_o)) inside {5'h08, 5'h10, 5'h18};
	endproperty
	a_byte_len: assert property (p_byte_len) else $error("byte length");
endmodule // spi_rate_chk
bind spi_rate_flags spi_rate_chk u_spi_rate_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.req_i(req_i), .rdata_o(rdata_o), .serial_clk_o(serial_clk_o),
	.select_n_o(select_n_o), .select_oe_o(select_oe_o), .irq_o(irq_o));
`default_nettype wire

// ### bench/spi_slave_model.sv
/*
 far-side slave: sends 3c, c3, 3c... one byte per eight clocks.
 assumes idle-low clock, bits held rise to rise, sampled at the fall.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model
(
	// master pins
	input  wire logic serial_clk_i,
	input  wire logic select_n_i,
	input  wire logic serial_data_i,
	// reply and last byte heard from the master
	output logic      miso_o,
	output logic [7:0] sent_o
);
	int         rise_cnt = 0;
	int         byte_cnt = 0;
	logic [7:0] cur_byte;
	logic [7:0] heard = 8'h00;
	initial miso_o = 1'b1;
	initial sent_o = 8'h00;
	always @(negedge select_n_i)
	begin
		rise_cnt = 0;
		cur_byte = byte_cnt[0] ? 8'hc3 : 8'h3c;
		miso_o = cur_byte[7];
	end
	// released line shows no stale bit
	always @(posedge select_n_i)
	begin
		byte_cnt++;
		miso_o = ~miso_o;
		sent_o = heard;
	end
	always @(posedge serial_clk_i)
	begin
		rise_cnt++;
		// master data bit stands steady across the rise
		heard = {heard[6:0], serial_data_i};
		if (rise_cnt > 1 && (rise_cnt - 1) % 8 == 0) byte_cnt++;
		cur_byte = byte_cnt[0] ? 8'hc3 : 8'h3c;
		if (rise_cnt > 1) miso_o = cur_byte[7 - (rise_cnt - 1) % 8];
	end
endmodule // spi_slave_model
`default_nettype wire

// ### bench/tb.sv
/*
 self-checking bench of spi_rate_flags through its register port.
 assumes the slave model on the pins and the package offsets.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
	import spi_rate_pkg::*;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        select_n_i = 1'b1;
	reg_req_s    req_i = '0;
	wire logic [7:0] rdata_o;
	wire logic [7:0] sent;
	wire logic   serial_in_i, serial_out_o, serial_clk_o, select_n_o, select_oe_o, irq_o;
	int          n_mismatch = 0;
	int          checked = 0;
	int          falls = 0;
	int          nb = 0;
	logic [7:0]  rd_val;
	logic [15:0] cfg [3] = '{16'h5000, 16'h5210, 16'h4010};
	always #5 clk_i = ~clk_i;
	always @(negedge serial_clk_o) falls++;
	spi_rate_flags u_spi_rate_flags (.clk_i, .reset_n_i, .req_i, .rdata_o, .select_n_i,
		.serial_in_i, .serial_out_o, .serial_clk_o, .select_n_o, .select_oe_o, .irq_o);
	spi_slave_model u_spi_slave_model (.serial_clk_i(serial_clk_o),
		.select_n_i(select_n_o), .serial_data_i(serial_out_o), .miso_o(serial_in_i),
		.sent_o(sent));
	task automatic finish_test;
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one access, then a quiet cycle; read data taken in its only cycle
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_i <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk_i);
		req_i <= '0;
		#1 rd_val = rdata_o;
	endtask
	task automatic st(input logic [7:0] e);
		acc(1'b0, FLAG_STATUS_OFFSET, 8'h00);
		check("status", rd_val, e);
	endtask
	task automatic rx;
		acc(1'b0, DATA_PORT_OFFSET, 8'h00);
		check("rx data", rd_val, nb[0] ? 8'hc3 : 8'h3c);
	endtask
	task automatic settle;
		int idle;
		idle = 0;
		for (int i = 0; i < 20000 && idle < 8; i++)
		begin
			@(posedge clk_i);
			idle = select_n_o ? idle + 1 : 0;
		end
		if (idle < 8) n_mismatch++;
	endtask
	initial
	begin
		#1000000;
		n_mismatch++;
		finish_test();
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		st(8'h20);
		acc(1'b1, FLAG_STATUS_OFFSET, 8'hff);
		st(8'h20);
		acc(1'b1, BIT_RATE_OFFSET, 8'hff);
		acc(1'b0, BIT_RATE_OFFSET, 8'h00);
		check("rate", rd_val, 8'h77);
		acc(1'b1, CTRL_ONE_OFFSET, 8'h50);
		// every prescale and rate code, slowest last
		for (int k = 0; k < 8; k++)
		begin
			acc(1'b1, BIT_RATE_OFFSET, {1'b0, 3'(k), 1'b0, 3'(k)});
			st(8'h20);
			acc(1'b1, DATA_PORT_OFFSET, 8'(k));
			settle();
			check("mosi", sent, 8'(k));
			st(8'ha0);
			rx();
			st(8'h20);
			nb++;
		end
		acc(1'b1, BIT_RATE_OFFSET, 8'h01);
		falls = 0;
		st(8'h20);
		acc(1'b1, DATA_PORT_OFFSET, 8'ha5);
		st(8'h20);
		acc(1'b1, DATA_PORT_OFFSET, 8'h96);
		st(8'h00);
		acc(1'b1, DATA_PORT_OFFSET, 8'h11);
		settle();
		check("falls", 8'(falls), 8'h10);
		check("mosi", sent, 8'h96);
		st(8'ha0);
		rx();
		nb += 2;
		st(8'h20);
		acc(1'b1, DATA_PORT_OFFSET, 8'h33);
		st(8'h20);
		acc(1'b1, DATA_PORT_OFFSET, 8'h44);
		acc(1'b1, CTRL_ONE_OFFSET, 8'h10);
		st(8'h20);
		check("select", {7'h00, select_n_o}, 8'h01);
		@(posedge clk_i);
		select_n_i <= 1'b0;
		foreach (cfg[i])
		begin
			acc(1'b1, CTRL_ONE_OFFSET, cfg[i][15:8]);
			acc(1'b1, CTRL_TWO_OFFSET, cfg[i][7:0]);
			st(8'h20);
		end
		acc(1'b1, CTRL_ONE_OFFSET, 8'h50);
		st(8'h30);
		check("irq", {7'h00, irq_o}, 8'h00);
		acc(1'b1, CTRL_ONE_OFFSET, 8'hd0);
		st(8'h30);
		check("irq", {7'h00, irq_o}, 8'h01);
		@(posedge clk_i);
		select_n_i <= 1'b1;
		st(8'h30);
		acc(1'b1, CTRL_ONE_OFFSET, 8'h50);
		st(8'h20);
		acc(1'b1, CTRL_ONE_OFFSET, 8'h70);
		check("irq", {7'h00, irq_o}, 8'h01);
		st(8'h20);
		finish_test();
	end
endmodule // tb
`default_nettype wire
